// ---- design/sfrb_pkg.sv ----
package sfrb_pkg;

   // opcodes, shifted in msb first
   localparam logic [7:0] OP_CAR_LOW = 8'h03;
   localparam logic [7:0] OP_PAGE_RD = 8'hD2;
   localparam logic [7:0] OP_BUF1_RD_HI = 8'hD4;
   localparam logic [7:0] OP_BUF1_RD_LO = 8'hD1;
   localparam logic [7:0] OP_BUF2_RD_HI = 8'hD6;
   localparam logic [7:0] OP_BUF2_RD_LO = 8'hD3;
   localparam logic [7:0] OP_BUF1_WR = 8'h84;
   localparam logic [7:0] OP_BUF2_WR = 8'h87;

   // field sizes and positions
   localparam int PAGE_W = 11;
   localparam int BYTE_W = 9;
   localparam int ADDR_BITS = 24;
   localparam int OP_BITS = 8;
   localparam int CNT_W = 6;
   localparam int A264_PAGE_LSB = 9;
   localparam int A256_PAGE_LSB = 8;
   localparam int BUF_BYTES_264 = 264;

   // phase lengths in serial clocks, minus one
   localparam logic [CNT_W-1:0] OP_LAST = 6'h07;
   localparam logic [CNT_W-1:0] ADDR_LAST = 6'h17;
   localparam logic [CNT_W-1:0] DUMMY_NONE = 6'h00;
   localparam logic [CNT_W-1:0] DUMMY_PAGE_LAST = 6'h1F;
   localparam logic [CNT_W-1:0] DUMMY_BUF_LAST = 6'h07;
   localparam logic [2:0] BIT_MSB = 3'h7;
   localparam logic [2:0] BIT_LSB = 3'h0;

   // last byte of a page or buffer
   localparam logic [BYTE_W-1:0] LAST_264 = 9'h107;
   localparam logic [BYTE_W-1:0] LAST_256 = 9'h0FF;

   // synchroniser reset: cs_n idles high
   localparam logic [2:0] SYNC_RST = 3'h1;

   typedef enum logic [2:0] {
      ST_IDLE, ST_OPCODE, ST_ADDR, ST_DUMMY, ST_READ, ST_WRITE,
      ST_IGNORE
   } sfrb_state_t;

   typedef enum logic [1:0] {
      CMD_CAR, CMD_PAGE, CMD_BUF_RD, CMD_BUF_WR
   } sfrb_cmd_t;

   typedef struct packed {
      logic cs_n;
      logic cs_fall;
      logic sck_rise;
      logic sck_fall;
      logic si;
   } sfrb_pins_t;

   typedef struct packed {
      logic en;
      logic sel;
      logic [BYTE_W-1:0] addr;
      logic [7:0] data;
   } sfrb_bufwr_t;

endpackage

// ---- design/sfrb_pin_sync.sv ----
`timescale 1ns/100ps
`default_nettype none
module sfrb_pin_sync import sfrb_pkg::*; (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // raw pins
   input wire logic i_cs_n,
   input wire logic i_sck,
   input wire logic i_si,
   // synchronised levels and edges
   output sfrb_pins_t o_pins
);
   // bit 0 cs_n, bit 1 sck, bit 2 si
   logic [2:0] meta_reg;
   logic [2:0] sync_reg;
   logic [2:0] prev_reg;

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         meta_reg <= SYNC_RST;
         sync_reg <= SYNC_RST;
         prev_reg <= SYNC_RST;
      end else begin
         meta_reg <= {i_si, i_sck, i_cs_n};
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   // edges are judged on the second and third stages only
   // one assignment drives the whole struct, so it has a single driver
   assign o_pins = '{
      cs_n: sync_reg[0],
      cs_fall: prev_reg[0] & ~sync_reg[0],
      sck_rise: ~prev_reg[1] & sync_reg[1],
      sck_fall: prev_reg[1] & ~sync_reg[1],
      si: sync_reg[2]
   };
endmodule
`default_nettype wire

// ---- design/sfrb_buf.sv ----
`timescale 1ns/100ps
`default_nettype none
module sfrb_buf import sfrb_pkg::*; #(
   parameter int DEPTH = BUF_BYTES_264
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // write port
   input wire sfrb_bufwr_t i_wr,
   // read port, data one clock after address
   input wire logic i_rd_sel,
   input wire logic [BYTE_W-1:0] i_rd_addr,
   output logic [7:0] o_rd_data
);
   logic [7:0] mem [2][DEPTH];

   // contents are not reset, as in a real sram
   always_ff @(posedge i_clk) begin
      if (i_wr.en && (int'(i_wr.addr) < DEPTH)) begin
         mem[i_wr.sel][i_wr.addr] <= i_wr.data;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_rd_data <= 8'h00;
      end else if (int'(i_rd_addr) < DEPTH) begin
         o_rd_data <= mem[i_rd_sel][i_rd_addr];
      end else begin
         o_rd_data <= 8'h00;
      end
   end
endmodule
`default_nettype wire

// ---- design/sfrb_seq.sv ----
// Functional notes
// - opcode 03H, three address bytes, data follows with no dummy byte
// - 264-byte pages: address bits 19..9 page, 8..0 start byte
// - 256-byte pages: address bits 18..8 page, 7..0 start byte
// - continuous read shifts one data bit per clock after address
// - continuous read crosses into next page without pause
// - after last array bit, continuous read restarts at page zero
// - chip select rising ends any read and floats the output
// - array reads never alter either sram buffer
// - D2H, address, four dummy bytes, then page data, any page
// - page read wraps to start of the same page
// - buffer read opcodes D4H/D1H buffer one, D6H/D3H buffer two
// - buffer read offset is low 9 or 8 address bits
// - buffer read needs exactly one dummy byte before data
// - buffer read wraps to buffer start after last byte
// - buffer write opcodes 84H buffer one, 87H buffer two
// - buffer write offset picks the first byte written
// - buffer write stores following bytes at consecutive offsets
// - buffer write wraps to offset zero and keeps storing
// - buffer write lasts until chip select rises
// - opcode, address and data move msb first
// - command opens on chip select fall; first byte is opcode
// - serial modes 0 and 3 are both supported
`timescale 1ns/100ps
`default_nettype none
module sfrb_seq import sfrb_pkg::*; #(
   parameter int BUF_DEPTH = BUF_BYTES_264
) (
   // clock and reset
   input wire logic I_SYS_CLK,
   input wire logic I_NRST,
   // serial pins
   input wire logic I_CS_N,
   input wire logic I_SCK,
   input wire logic I_SI,
   output logic O_SO,
   output logic O_SO_OE,
   // static configuration
   input wire logic I_PAGE_256,
   // main array read port
   output logic [PAGE_W-1:0] O_ARR_PAGE,
   output logic [BYTE_W-1:0] O_ARR_BYTE,
   input wire logic [7:0] I_ARR_DATA
);
   sfrb_pins_t pins;
   sfrb_state_t state_reg;
   sfrb_cmd_t cmd_reg;
   logic buf_sel_reg;
   logic [CNT_W-1:0] cnt_reg;
   logic [ADDR_BITS-1:0] addr_sh_reg;
   logic [7:0] in_sh_reg;
   logic [PAGE_W-1:0] page_reg;
   logic [BYTE_W-1:0] byte_reg;
   logic [7:0] out_byte_reg;
   logic [2:0] bit_idx_reg;
   logic [1:0] pend_reg;
   logic so_reg;
   logic oe_reg;
   sfrb_bufwr_t bw_reg;
   logic [7:0] buf_rd_data;
   logic rise;
   logic fall;
   logic [7:0] op_full;
   logic [ADDR_BITS-1:0] addr_full;
   logic [CNT_W-1:0] dummy_last;
   logic enter_read;
   logic load;
   logic [7:0] src;
   logic [BYTE_W-1:0] last_byte;
   logic byte_done;

   function automatic logic [BYTE_W-1:0] last_of(input logic p256);
      return p256 ? LAST_256 : LAST_264;
   endfunction

   function automatic logic [CNT_W-1:0] dummy_of(input sfrb_cmd_t c);
      case (c)
         CMD_PAGE: return DUMMY_PAGE_LAST;
         CMD_BUF_RD: return DUMMY_BUF_LAST;
         default: return DUMMY_NONE;
      endcase
   endfunction

   sfrb_pin_sync u_sync (
      .i_clk(I_SYS_CLK),
      .i_nrst(I_NRST),
      .i_cs_n(I_CS_N),
      .i_sck(I_SCK),
      .i_si(I_SI),
      .o_pins(pins)
   );

   sfrb_buf #(
      .DEPTH(BUF_DEPTH)
   ) u_buf (
      .i_clk(I_SYS_CLK),
      .i_nrst(I_NRST),
      .i_wr(bw_reg),
      .i_rd_sel(buf_sel_reg),
      .i_rd_addr(byte_reg),
      .o_rd_data(buf_rd_data)
   );

   // input sampled on sck rise, output moved on sck fall: modes 0 and 3
   assign rise = pins.sck_rise & ~pins.cs_n;
   assign fall = pins.sck_fall & ~pins.cs_n;
   assign op_full = {in_sh_reg[6:0], pins.si};
   assign addr_full = {addr_sh_reg[ADDR_BITS-2:0], pins.si};
   assign dummy_last = dummy_of(cmd_reg);
   assign last_byte = last_of(I_PAGE_256);
   assign enter_read = rise && cmd_reg != CMD_BUF_WR &&
      ((state_reg == ST_ADDR && cnt_reg == ADDR_LAST &&
        dummy_last == DUMMY_NONE) ||
       (state_reg == ST_DUMMY && cnt_reg == dummy_last));
   assign load = pend_reg[1] ||
      (fall && state_reg == ST_READ && bit_idx_reg == BIT_LSB);
   assign src = (cmd_reg == CMD_BUF_RD) ? buf_rd_data : I_ARR_DATA;
   assign byte_done = rise && state_reg == ST_WRITE &&
      cnt_reg[2:0] == BIT_MSB;

   // serial input shifter, msb first
   always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         in_sh_reg <= 8'h00;
         addr_sh_reg <= '0;
      end else if (rise) begin
         in_sh_reg <= op_full;
         addr_sh_reg <= addr_full;
      end
   end

   // command sequencing
   always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         state_reg <= ST_IDLE;
         cmd_reg <= CMD_CAR;
         buf_sel_reg <= 1'b0;
         cnt_reg <= '0;
      end else if (pins.cs_n) begin
         state_reg <= ST_IDLE;
         cnt_reg <= '0;
      end else if (pins.cs_fall) begin
         state_reg <= ST_OPCODE;
         cnt_reg <= '0;
      end else if (rise) begin
         cnt_reg <= CNT_W'(cnt_reg + 6'h01);
         case (state_reg)
            ST_OPCODE: begin
               if (cnt_reg == OP_LAST) begin
                  cnt_reg <= '0;
                  state_reg <= ST_ADDR;
                  case (op_full)
                     OP_CAR_LOW: cmd_reg <= CMD_CAR;
                     OP_PAGE_RD: cmd_reg <= CMD_PAGE;
                     OP_BUF1_RD_HI, OP_BUF1_RD_LO: begin
                        cmd_reg <= CMD_BUF_RD;
                        buf_sel_reg <= 1'b0;
                     end
                     OP_BUF2_RD_HI, OP_BUF2_RD_LO: begin
                        cmd_reg <= CMD_BUF_RD;
                        buf_sel_reg <= 1'b1;
                     end
                     OP_BUF1_WR: begin
                        cmd_reg <= CMD_BUF_WR;
                        buf_sel_reg <= 1'b0;
                     end
                     OP_BUF2_WR: begin
                        cmd_reg <= CMD_BUF_WR;
                        buf_sel_reg <= 1'b1;
                     end
                     default: state_reg <= ST_IGNORE;
                  endcase
               end
            end
            ST_ADDR: begin
               if (cnt_reg == ADDR_LAST) begin
                  cnt_reg <= '0;
                  if (cmd_reg == CMD_BUF_WR) begin
                     state_reg <= ST_WRITE;
                  end else if (dummy_last == DUMMY_NONE) begin
                     state_reg <= ST_READ;
                  end else begin
                     state_reg <= ST_DUMMY;
                  end
               end
            end
            ST_DUMMY: begin
               if (cnt_reg == dummy_last) begin
                  cnt_reg <= '0;
                  state_reg <= ST_READ;
               end
            end
            ST_WRITE: begin
               if (cnt_reg[2:0] == BIT_MSB) begin
                  cnt_reg <= '0;
               end
            end
            ST_READ, ST_IGNORE: cnt_reg <= '0;
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // address pointer: start address, then advance with wrap
   always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         page_reg <= '0;
         byte_reg <= '0;
      end else if (rise && state_reg == ST_ADDR && cnt_reg == ADDR_LAST) begin
         if (cmd_reg == CMD_BUF_RD || cmd_reg == CMD_BUF_WR) begin
            page_reg <= '0;
            if (I_PAGE_256) begin
               byte_reg <= {1'b0, addr_full[A256_PAGE_LSB-1:0]};
            end else begin
               byte_reg <= addr_full[BYTE_W-1:0];
            end
         end else if (I_PAGE_256) begin
            page_reg <= addr_full[A256_PAGE_LSB +: PAGE_W];
            byte_reg <= {1'b0, addr_full[A256_PAGE_LSB-1:0]};
         end else begin
            page_reg <= addr_full[A264_PAGE_LSB +: PAGE_W];
            byte_reg <= addr_full[A264_PAGE_LSB-1:0];
         end
      end else if (load || byte_done) begin
         if (byte_reg != last_byte) begin
            byte_reg <= BYTE_W'(byte_reg + 9'h001);
         end else begin
            byte_reg <= '0;
            if (cmd_reg == CMD_CAR) begin
               // page counter rolls from the top page to zero
               page_reg <= PAGE_W'(page_reg + 11'h001);
            end
         end
      end
   end

   // two-clock prefetch so sram and array data are settled
   always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         pend_reg <= 2'h0;
      end else if (pins.cs_n) begin
         pend_reg <= 2'h0;
      end else begin
         pend_reg <= {pend_reg[0], enter_read};
      end
   end

   // output shifter
   always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         out_byte_reg <= 8'h00;
         bit_idx_reg <= BIT_MSB;
         so_reg <= 1'b0;
      end else begin
         if (enter_read) begin
            bit_idx_reg <= BIT_MSB;
         end else if (fall && state_reg == ST_READ) begin
            so_reg <= out_byte_reg[bit_idx_reg];
            bit_idx_reg <= 3'(bit_idx_reg - 3'h1);
         end
         if (load) begin
            // array reads bypass the buffers entirely
            out_byte_reg <= src;
         end
      end
   end

   // output enable drops one clock after cs is seen high
   always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         oe_reg <= 1'b0;
      end else begin
         oe_reg <= !pins.cs_n && state_reg == ST_READ;
      end
   end

   // buffer write port; a partial byte at cs rise is dropped
   always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         bw_reg <= '0;
      end else begin
         bw_reg.en <= byte_done;
         if (byte_done) begin
            bw_reg.sel <= buf_sel_reg;
            bw_reg.addr <= byte_reg;
            bw_reg.data <= op_full;
         end
      end
   end

   assign O_SO = so_reg;
   assign O_SO_OE = oe_reg;
   assign O_ARR_PAGE = page_reg;
   assign O_ARR_BYTE = byte_reg;

   low_read_entry_a: assert property (
      @(posedge I_SYS_CLK) disable iff (!I_NRST)
      (rise && state_reg == ST_ADDR && cnt_reg == ADDR_LAST &&
       cmd_reg == CMD_CAR) |=> (state_reg == ST_READ) ##1 pend_reg[1])
      else $error("low read did not start data after address");

   cs_high_float_a: assert property (
      @(posedge I_SYS_CLK) disable iff (!I_NRST)
      pins.cs_n |=> !O_SO_OE && state_reg == ST_IDLE)
      else $error("output driven after chip select high");

   bad_op_quiet_a: assert property (
      @(posedge I_SYS_CLK) disable iff (!I_NRST)
      state_reg == ST_IGNORE |=> !O_SO_OE)
      else $error("output driven for unknown opcode");

   page_cross_a: assert property (
      @(posedge I_SYS_CLK) disable iff (!I_NRST)
      (load && cmd_reg == CMD_CAR && byte_reg == last_byte &&
       !(rise && state_reg == ST_ADDR)) |=>
      byte_reg == '0 && page_reg == PAGE_W'($past(page_reg) + 11'h001))
      else $error("continuous read failed to enter next page");

   array_wrap_a: assert property (
      @(posedge I_SYS_CLK) disable iff (!I_NRST)
      (load && cmd_reg == CMD_CAR && byte_reg == last_byte &&
       &page_reg) |=> page_reg == '0)
      else $error("continuous read failed to wrap to page zero");

   page_wrap_a: assert property (
      @(posedge I_SYS_CLK) disable iff (!I_NRST)
      (load && cmd_reg == CMD_PAGE && byte_reg == last_byte) |=>
      byte_reg == '0 && $stable(page_reg))
      else $error("page read left its page");

   buf_rd_wrap_a: assert property (
      @(posedge I_SYS_CLK) disable iff (!I_NRST)
      (load && cmd_reg == CMD_BUF_RD && byte_reg == last_byte) |=>
      byte_reg == '0)
      else $error("buffer read did not wrap");

   buf_wr_wrap_a: assert property (
      @(posedge I_SYS_CLK) disable iff (!I_NRST)
      (byte_done && byte_reg == last_byte) |=>
      bw_reg.en && bw_reg.addr == last_byte && byte_reg == '0)
      else $error("buffer write did not wrap to zero");

   buf_untouched_a: assert property (
      @(posedge I_SYS_CLK) disable iff (!I_NRST)
      bw_reg.en |-> cmd_reg == CMD_BUF_WR && $past(state_reg) == ST_WRITE)
      else $error("buffer written outside a buffer write");
endmodule
`default_nettype wire

// ---- sim/sfrb_host.sv ----
`timescale 1ns/100ps
`default_nettype none
module sfrb_host (
   // clock
   input wire logic i_clk,
   // device side
   input wire logic i_so,
   input wire logic i_so_oe,
   // host pins
   output logic o_cs_n,
   output logic o_sck,
   output logic o_si
);
   logic [7:0] tx [0:299];
   logic [7:0] rx [0:299];
   logic [7:0] rx_oe [0:299];

   initial begin
      o_cs_n = 1'b1;
      o_sck = 1'b0;
      o_si = 1'b0;
   end

   // sends ntx bytes of tx, then clocks nrx bytes into rx
   // hp is the sck half period in clocks; m3 picks idle-high sck
   task automatic frame(input int ntx, input int nrx, input int hp,
                        input bit m3);
      int i;
      int b;
      o_sck = m3;
      repeat (hp) @(negedge i_clk);
      o_cs_n = 1'b0;
      repeat (hp) @(negedge i_clk);
      for (i = 0; i < ntx + nrx; i++) begin
         for (b = 7; b >= 0; b--) begin
            o_sck = 1'b0;
            // msb first; during reads si is random so nothing leans on it
            o_si = (i < ntx) ? tx[i][b] : 1'($urandom);
            repeat (hp) @(negedge i_clk);
            if (i >= ntx) begin
               // a floating line reads as the inverse of its last value
               rx[i - ntx][b] = i_so_oe ? i_so : ~i_so;
               rx_oe[i - ntx][b] = i_so_oe;
            end
            // half period of 4 clocks or more stays one clock above the 3-clock minimum
            o_sck = 1'b1;
            repeat (hp) @(negedge i_clk);
         end
      end
      o_sck = m3;
      repeat (hp) @(negedge i_clk);
      // chip select held low from opcode to last data bit
      o_cs_n = 1'b1;
      o_si = ~o_si;
      repeat (6) @(negedge i_clk);
   endtask
endmodule
`default_nettype wire

// ---- sim/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin \
   checks_done++; \
   if ((got) !== (ex)) begin \
      err_count++; \
      $display("wrong value %s expected %h seen %h", nm, ex, got); \
   end \
end
module tb import sfrb_pkg::*; ;
   logic clk;
   logic nrst;
   logic p256;
   wire logic cs_n;
   wire logic sck;
   wire logic si;
   logic so;
   logic so_oe;
   logic [PAGE_W-1:0] arr_page;
   logic [BYTE_W-1:0] arr_byte;
   logic [7:0] arr_data;
   logic [7:0] bufm [0:1][0:263];
   int err_count = 0;
   int checks_done = 0;
   int cycles = 0;
   int k;
   logic [7:0] rdop [0:3];

   function automatic logic [7:0] arr_val(input int pg, input int by);
      return 8'((pg * 37) ^ (by * 5) ^ (pg >> 3));
   endfunction

   // array contents are a fixed pattern of page and byte
   assign arr_data = arr_val(int'(arr_page), int'(arr_byte));

   sfrb_seq u_dut (
      .I_SYS_CLK(clk),
      .I_NRST(nrst),
      .I_CS_N(cs_n),
      .I_SCK(sck),
      .I_SI(si),
      .O_SO(so),
      .O_SO_OE(so_oe),
      .I_PAGE_256(p256),
      .O_ARR_PAGE(arr_page),
      .O_ARR_BYTE(arr_byte),
      .I_ARR_DATA(arr_data)
   );

   sfrb_host u_host (
      .i_clk(clk),
      .i_so(so),
      .i_so_oe(so_oe),
      .o_cs_n(cs_n),
      .o_sck(sck),
      .o_si(si)
   );

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic final_report();
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 80000) begin
         err_count++;
         final_report();
      end
   end

   task automatic do_reset(input logic mode);
      @(negedge clk);
      nrst = 1'b0;
      p256 = mode;
      repeat (4) @(negedge clk);
      nrst = 1'b1;
      repeat (6) @(negedge clk);
      `CHK("oe after reset", 1'b0, so_oe)
      `CHK("page after reset", 11'h000, arr_page)
      `CHK("byte after reset", 9'h000, arr_byte)
   endtask

   // one command: opcode, address, ndum dummy bytes, nwr data bytes,
   // then nrd bytes read and compared with the model
   task automatic cmd(input logic [7:0] op, input int a, input int ndum,
                      input int nwr, input int nrd, input int hp,
                      input bit m3);
      int i;
      int sz;
      int off;
      int sel;
      int pg;
      int lin;
      logic [7:0] ex;
      bit known;
      u_host.tx[0] = op;
      u_host.tx[1] = 8'(a >> 16);
      u_host.tx[2] = 8'(a >> 8);
      u_host.tx[3] = 8'(a);
      for (i = 0; i < ndum + nwr; i++) begin
         u_host.tx[4 + i] = 8'($urandom);
      end
      sz = p256 ? 256 : 264;
      sel = (op == OP_BUF2_WR || op == OP_BUF2_RD_HI ||
             op == OP_BUF2_RD_LO) ? 1 : 0;
      off = a % (p256 ? 256 : 512);
      pg = (p256 ? (a >> 8) : (a >> 9)) % 2048;
      u_host.frame(4 + ndum + nwr, nrd, hp, m3);
      for (i = 0; i < nwr; i++) begin
         bufm[sel][(off + i) % sz] = u_host.tx[4 + i];
      end
      for (i = 0; i < nrd; i++) begin
         known = 1'b1;
         case (op)
            OP_CAR_LOW: begin
               lin = (pg * sz + off + i) % (2048 * sz);
               ex = arr_val(lin / sz, lin % sz);
            end
            OP_PAGE_RD: begin
               ex = arr_val(pg, (off + i) % sz);
            end
            OP_BUF1_RD_HI, OP_BUF1_RD_LO, OP_BUF2_RD_HI, OP_BUF2_RD_LO: begin
               ex = bufm[sel][(off + i) % sz];
            end
            default: begin
               known = 1'b0;
               ex = 8'h00;
            end
         endcase
         if (known) begin
            `CHK("read byte", ex, u_host.rx[i])
            `CHK("oe in read", 8'hFF, u_host.rx_oe[i])
         end else begin
            `CHK("oe ignored", 8'h00, u_host.rx_oe[i])
         end
      end
      `CHK("oe after cs", 1'b0, so_oe)
   endtask

   initial begin
      nrst = 1'b0;
      p256 = 1'b0;
      void'($urandom(32'hA1E8));
      rdop = '{OP_BUF1_RD_HI, OP_BUF1_RD_LO, OP_BUF2_RD_HI, OP_BUF2_RD_LO};
      do_reset(1'b0);
      // buffer writes that wrap, with don't-care address bits set
      cmd(OP_BUF1_WR, 24'hFFFF04, 0, 8, 0, 4, 1'b0);
      cmd(OP_BUF2_WR, 24'hFFFF06, 0, 6, 0, 4, 1'b1);
      // array reads and an unknown opcode between writes and buffer reads leave buffers alone
      cmd(OP_CAR_LOW, 24'h0FFF06, 0, 0, 4, 4, 1'b0);
      cmd(OP_PAGE_RD, 24'h00C906, 4, 0, 4, 4, 1'b1);
      cmd(8'h0B, 24'h000000, 0, 0, 2, 4, 1'b0);
      // every buffer read opcode; low-rate ones clocked slower
      for (k = 0; k < 4; k++) begin
         cmd(rdop[k], 24'hFFFE00 | ((k % 2) ? 0 : 261 + k / 2), 1, 0,
             (k % 2) ? 4 : 5 + k / 2, (k % 2) ? 6 : 4, k[0]);
      end
      // 256-byte pages after a second reset
      do_reset(1'b1);
      cmd(OP_CAR_LOW, 24'h0005FE, 0, 0, 4, 6, 1'b1);
      cmd(OP_PAGE_RD, 24'h07FFFF, 4, 0, 3, 4, 1'b0);
      cmd(OP_BUF1_WR, 24'h00FFFE, 0, 4, 0, 4, 1'b0);
      cmd(OP_BUF1_RD_HI, 24'h0000FF, 1, 0, 3, 4, 1'b1);
      k = int'($urandom % 256);
      cmd(OP_BUF2_WR, k, 0, 3, 0, 4, 1'b1);
      cmd(OP_BUF2_RD_LO, k, 1, 0, 3, 6, 1'b0);
      final_report();
   end
endmodule
`default_nettype wire
